//--- pkg/sbie_pkg.sv
// package for the skip, branch and increment/decrement execution block
// ==========================================================================
// Notes on behaviour
// - decrement file, skip next when result zero
// - increment file, skip next when result zero
// - destination bit zero picks work, one file
// - jump loads immediate low, latch fills upper
// - jump takes two cycles, flags untouched
// - or literal into work, update zero flag
// - or literal result always goes to work
`default_nettype none
package sbie_pkg;

  // ==========================================================================
  // widths
  localparam int DATA_W  = 8;            // file and work register width
  localparam int ADDR_W  = 7;            // file address width
  localparam int IMM_W   = 11;           // jump immediate width
  localparam int PC_W    = 15;           // program counter width
  localparam int LATCH_W = 7;            // program counter latch width
  localparam int LAT_LO  = 3;            // latch bit feeding pc bit 11
  localparam int LAT_HI  = 6;            // latch bit feeding pc bit 14

  // reset values
  localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
  localparam logic [PC_W-1:0]   PC_RST   = 15'h0000;

  // ==========================================================================
  // operations handled here
  typedef enum logic [2:0] {
    SBIE_OP_NONE,
    SBIE_OP_DEC_SKIP,
    SBIE_OP_INC_SKIP,
    SBIE_OP_JUMP,
    SBIE_OP_OR_LIT,
    SBIE_OP_INC_FILE
  } sbie_op_t;

  // issue stage states
  typedef enum logic [1:0] {
    SBIE_ST_RUN,
    SBIE_ST_NOP
  } sbie_state_t;

  // one instruction as presented by the decode stage
  typedef struct packed {
    logic                  valid;  // instruction present this cycle
    sbie_op_t              op;     // decoded operation
    logic [ADDR_W-1:0]     faddr;  // file register address
    logic                  dest;   // 0 work, 1 file
    logic [IMM_W-1:0]      imm;    // literal or jump target
  } sbie_instr_t;

  // file register write back
  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } sbie_fwr_t;

  // complete block state
  typedef struct packed {
    sbie_state_t       st;       // run or inserted no-op
    logic [DATA_W-1:0] work;     // work register
    logic              zero;     // zero flag
    logic [PC_W-1:0]   pc;       // program counter
    sbie_fwr_t         fwr;      // file write pulse
    logic              pc_load;  // pc loaded from jump, pulse
    logic              busy;     // second cycle of a two-cycle instruction
    logic              done;     // instruction retired, pulse
  } sbie_state_s_t;

endpackage : sbie_pkg
`default_nettype wire

//--- core/sbie_exec.sv
// execution core for skip, jump, or-literal and increment instructions
`timescale 1ns/100ps
`default_nettype none

module sbie_exec (
  // clock and reset
  input  wire logic                               clk,
  input  wire logic                               rst,
  // instruction in
  input  wire sbie_pkg::sbie_instr_t              instr,
  input  wire logic [sbie_pkg::DATA_W-1:0]        file_rd,
  input  wire logic [sbie_pkg::LATCH_W-1:0]       pc_latch_high,
  // results out
  output logic [sbie_pkg::ADDR_W-1:0]             file_addr,
  output sbie_pkg::sbie_fwr_t                     file_wr,
  output logic [sbie_pkg::DATA_W-1:0]             work_q,
  output logic                                    zero_q,
  output logic [sbie_pkg::PC_W-1:0]               pc_q,
  output logic                                    pc_load_q,
  output logic                                    busy_q,
  output logic                                    done_q
);

  // ==========================================================================
  // state
  // every flop of the core lives in one packed struct; the arithmetic results
  // below are formed every cycle and only the one that the operation picks is used
  sbie_pkg::sbie_state_s_t s_q;   // registered state
  sbie_pkg::sbie_state_s_t s_d;   // next state
  logic [sbie_pkg::DATA_W-1:0] inc_v;  // file plus one
  logic [sbie_pkg::DATA_W-1:0] dec_v;  // file minus one
  logic [sbie_pkg::DATA_W-1:0] res_v;  // selected arithmetic result

  // ==========================================================================
  // next state
  // one combinational pass works out the whole next state from the registered
  // state and the instruction on the decode port; pulses fall back to zero by
  // default so that every write, load and retire lasts a single cycle
  always_comb begin
    // both neighbours of the file value, wrapping at the ends of the byte
    inc_v = file_rd + 8'h01;
    dec_v = file_rd - 8'h01;
    res_v = 8'h00;
    s_d = s_q;
    s_d.fwr.we = 1'b0;
    s_d.pc_load = 1'b0;
    s_d.done = 1'b0;
    s_d.busy = 1'b0;
    case (s_q.st)
      // inserted no-op: the following instruction is dropped
      sbie_pkg::SBIE_ST_NOP: begin
        s_d.st = sbie_pkg::SBIE_ST_RUN;
        s_d.done = 1'b1;
      end
      // run: take the instruction on the decode port when it is valid
      sbie_pkg::SBIE_ST_RUN: begin
        if (instr.valid) begin
          case (instr.op)
            sbie_pkg::SBIE_OP_DEC_SKIP,
            sbie_pkg::SBIE_OP_INC_SKIP,
            sbie_pkg::SBIE_OP_INC_FILE: begin
              // decrement for the decrement-skip form, otherwise increment
              res_v = (instr.op == sbie_pkg::SBIE_OP_DEC_SKIP) ? dec_v : inc_v;
              // destination bit: one writes the file back, zero loads work
              if (instr.dest) begin
                s_d.fwr.we = 1'b1;
                s_d.fwr.addr = instr.faddr;
                s_d.fwr.data = res_v;
              end else begin
                s_d.work = res_v;
              end
              if (instr.op == sbie_pkg::SBIE_OP_INC_FILE) begin
                s_d.zero = (res_v == 8'h00);
                s_d.done = 1'b1;
              end else if (res_v == 8'h00) begin
                // flags untouched; skip the next slot
                s_d.st = sbie_pkg::SBIE_ST_NOP;
                s_d.busy = 1'b1;
              end else begin
                s_d.done = 1'b1;
              end
            end
            // jump: low bits from the immediate, high bits from the latch;
            // the slot behind it is flushed just like a taken skip
            sbie_pkg::SBIE_OP_JUMP: begin
              s_d.pc = {pc_latch_high[sbie_pkg::LAT_HI:sbie_pkg::LAT_LO], instr.imm};
              s_d.pc_load = 1'b1;
              s_d.st = sbie_pkg::SBIE_ST_NOP;
              s_d.busy = 1'b1;
            end
            // or literal: only the low byte of the immediate is the literal,
            // and the result never reaches the file
            sbie_pkg::SBIE_OP_OR_LIT: begin
              res_v = s_q.work | instr.imm[sbie_pkg::DATA_W-1:0];
              s_d.work = res_v;
              s_d.zero = (res_v == 8'h00);
              s_d.done = 1'b1;
            end
            // unknown or absent operation: nothing is written and nothing
            // retires, so the bench sees no result for it
            default: begin
              s_d.done = 1'b0;
            end
          endcase
        end
      end
      // an unused state code falls back to run
      default: begin
        s_d.st = sbie_pkg::SBIE_ST_RUN;
      end
    endcase
  end

  // ==========================================================================
  // state register
  // asynchronous reset puts the core into the run state with work, flag and
  // program counter at their reset values and every pulse low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '{st: sbie_pkg::SBIE_ST_RUN, work: sbie_pkg::WORK_RST, zero: 1'b0,
               pc: sbie_pkg::PC_RST, fwr: '0, pc_load: 1'b0, busy: 1'b0, done: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // outputs
  // every result comes straight from the state flops; the file address is the
  // one exception: it feeds the read port of the file, whose data must come
  // back in the same cycle, so a register here would cost a whole cycle
  assign file_addr = instr.faddr;
  assign file_wr   = s_q.fwr;
  assign work_q    = s_q.work;
  assign zero_q    = s_q.zero;
  assign pc_q      = s_q.pc;
  assign pc_load_q = s_q.pc_load;
  assign busy_q    = s_q.busy;
  assign done_q    = s_q.done;

  // ==========================================================================
  // checks
  // the instruction checks look one cycle past the edge that took the instruction,
  // where its registered results stand; the decrement-to-zero skip and two-cycle jump checks look one cycle more
  chk_skip_inserts_nop: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == sbie_pkg::SBIE_ST_RUN && instr.valid && instr.op == sbie_pkg::SBIE_OP_DEC_SKIP
     && file_rd == 8'h01) |=> busy_q ##1 (done_q && !busy_q))
    else $error("decrement to zero did not skip");
  chk_incskip_nop: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == sbie_pkg::SBIE_ST_RUN && instr.valid && instr.op == sbie_pkg::SBIE_OP_INC_SKIP
     && file_rd == 8'hFF) |=> busy_q)
    else $error("increment to zero did not skip");
  chk_skip_flags_kept: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == sbie_pkg::SBIE_ST_RUN && instr.valid && (instr.op == sbie_pkg::SBIE_OP_DEC_SKIP
     || instr.op == sbie_pkg::SBIE_OP_INC_SKIP)) |=> $stable(zero_q))
    else $error("skip instruction changed zero flag");
  chk_dest_file_write: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == sbie_pkg::SBIE_ST_RUN && instr.valid && instr.dest && instr.op == sbie_pkg::SBIE_OP_INC_FILE)
    |=> (file_wr.we && file_wr.data == $past(file_rd) + 8'h01 && $stable(work_q)))
    else $error("file destination not written");
  chk_dest_work_write: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == sbie_pkg::SBIE_ST_RUN && instr.valid && !instr.dest && instr.op == sbie_pkg::SBIE_OP_DEC_SKIP)
    |=> (!file_wr.we && work_q == $past(file_rd) - 8'h01))
    else $error("work destination not written");
  chk_jump_target: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == sbie_pkg::SBIE_ST_RUN && instr.valid && instr.op == sbie_pkg::SBIE_OP_JUMP)
    |=> (pc_load_q && pc_q == {$past(pc_latch_high[6:3]), $past(instr.imm)}))
    else $error("jump target wrong");
  chk_jump_two_cycles: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == sbie_pkg::SBIE_ST_RUN && instr.valid && instr.op == sbie_pkg::SBIE_OP_JUMP)
    |=> (busy_q && $stable(zero_q)) ##1 (done_q && $stable(zero_q)))
    else $error("jump not two cycles");
  chk_or_literal: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == sbie_pkg::SBIE_ST_RUN && instr.valid && instr.op == sbie_pkg::SBIE_OP_OR_LIT)
    |=> (!file_wr.we && work_q == ($past(work_q) | $past(instr.imm[7:0])) && zero_q == (work_q == 8'h00)))
    else $error("or literal result wrong");
  chk_inc_zero: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == sbie_pkg::SBIE_ST_RUN && instr.valid && instr.op == sbie_pkg::SBIE_OP_INC_FILE)
    |=> (zero_q == ($past(file_rd) == 8'hFF) && !busy_q))
    else $error("increment zero flag wrong");
  chk_flush_slot_quiet: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == sbie_pkg::SBIE_ST_NOP) |=> (!file_wr.we && !busy_q && !pc_load_q && done_q
     && $stable(work_q) && $stable(zero_q) && $stable(pc_q)))
    else $error("skipped slot was not a no-op");
  chk_decskip_no_skip: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == sbie_pkg::SBIE_ST_RUN && instr.valid && instr.op == sbie_pkg::SBIE_OP_DEC_SKIP
     && file_rd != 8'h01) |=> (done_q && !busy_q))
    else $error("nonzero decrement did not retire in one cycle");
  chk_incskip_no_skip: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == sbie_pkg::SBIE_ST_RUN && instr.valid && instr.op == sbie_pkg::SBIE_OP_INC_SKIP
     && file_rd != 8'hFF) |=> (done_q && !busy_q))
    else $error("nonzero increment did not retire in one cycle");
  chk_skip_file_dest: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == sbie_pkg::SBIE_ST_RUN && instr.valid && instr.dest && instr.op == sbie_pkg::SBIE_OP_INC_SKIP)
    |=> (file_wr.we && file_wr.addr == $past(instr.faddr) && file_wr.data == $past(file_rd) + 8'h01))
    else $error("skip result not written to file");
  chk_inc_work_dest: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == sbie_pkg::SBIE_ST_RUN && instr.valid && !instr.dest && instr.op == sbie_pkg::SBIE_OP_INC_FILE)
    |=> (!file_wr.we && work_q == $past(file_rd) + 8'h01))
    else $error("increment not written to work");
  chk_pc_hold: assert property (@(posedge clk) disable iff (rst)
    !(s_q.st == sbie_pkg::SBIE_ST_RUN && instr.valid && instr.op == sbie_pkg::SBIE_OP_JUMP)
    |=> ($stable(pc_q) && !pc_load_q))
    else $error("program counter moved without a jump");
  chk_busy_one_cycle: assert property (@(posedge clk) disable iff (rst)
    busy_q |=> (!busy_q && done_q))
    else $error("two-cycle instruction did not retire on its second cycle");
  chk_jump_keeps_data: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == sbie_pkg::SBIE_ST_RUN && instr.valid && instr.op == sbie_pkg::SBIE_OP_JUMP)
    |=> (!file_wr.we && $stable(work_q)))
    else $error("jump touched work or file");
  chk_or_single_cycle: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == sbie_pkg::SBIE_ST_RUN && instr.valid && instr.op == sbie_pkg::SBIE_OP_OR_LIT)
    |=> (done_q && !busy_q && !pc_load_q))
    else $error("or literal did not retire in one cycle");

  // ==========================================================================
  // scenarios worth seeing
  cov_dec_skip: cover property (@(posedge clk) disable iff (rst) busy_q && !pc_load_q);
  cov_jump: cover property (@(posedge clk) disable iff (rst) pc_load_q);
  cov_or_zero: cover property (@(posedge clk) disable iff (rst) done_q && zero_q);
  cov_skip_to_file: cover property (@(posedge clk) disable iff (rst) busy_q && file_wr.we);
  cov_jump_retired: cover property (@(posedge clk) disable iff (rst) done_q && $past(pc_load_q));

endmodule : sbie_exec // sbie_exec

`default_nettype wire

//--- verification/sbie_exec_tb.sv
// self-checking bench for the skip, jump, or-literal and increment core
`timescale 1ns/100ps
`default_nettype none
module sbie_exec_tb;
  // ==========================================================================
  // expected outcome of one taken instruction
  typedef struct packed {
    logic        we;
    logic [6:0]  addr;
    logic [7:0]  data;
    logic [7:0]  work;
    logic        zero;
    logic [14:0] pc;
    logic        busy;
    logic        pcl;
  } sbie_note_t;
  logic                  clk, rst, zero_q, pc_load_q, busy_q, done_q;
  sbie_pkg::sbie_instr_t instr;
  sbie_pkg::sbie_fwr_t   file_wr;
  logic [7:0]            file_rd, work_q, m_work;
  logic [6:0]            pc_latch_high, file_addr;
  logic [14:0]           pc_q, m_pc;
  logic                  m_zero;
  int                    err_count, samples_checked;
  sbie_note_t            notes[$];
  sbie_exec dut (.clk, .rst, .instr, .file_rd, .pc_latch_high, .file_addr, .file_wr, .work_q, .zero_q, .pc_q,
                 .pc_load_q, .busy_q, .done_q);
  // clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // one comparison, counted
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (exp !== got) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // verdict and end of run
  task automatic summarize;
    if (err_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // drive one instruction at the falling edge and note what must follow
  task automatic issue(sbie_pkg::sbie_op_t op, logic [6:0] fa, logic d, logic [10:0] imm, logic [7:0] frd);
    sbie_note_t n;
    logic [7:0] r;
    n = '0;
    r = (op == sbie_pkg::SBIE_OP_DEC_SKIP) ? frd - 8'h01 : frd + 8'h01;
    case (op)
      sbie_pkg::SBIE_OP_DEC_SKIP, sbie_pkg::SBIE_OP_INC_SKIP, sbie_pkg::SBIE_OP_INC_FILE: begin
        n.we = d;
        n.addr = fa;
        n.data = r;
        if (!d) m_work = r;
        if (op == sbie_pkg::SBIE_OP_INC_FILE) m_zero = (r == 8'h00);
        else n.busy = (r == 8'h00);
      end
      sbie_pkg::SBIE_OP_OR_LIT: begin
        m_work = m_work | imm[7:0];
        m_zero = (m_work == 8'h00);
      end
      sbie_pkg::SBIE_OP_JUMP: begin
        m_pc = {pc_latch_high[6:3], imm};
        n.busy = 1'b1;
        n.pcl = 1'b1;
      end
      default: ;
    endcase
    {n.work, n.zero, n.pc} = {m_work, m_zero, m_pc};
    if (op inside {[3'd1:3'd5]}) notes.push_back(n);
    instr = '{1'b1, op, fa, d, imm};
    file_rd = frd;
    #1;
    check("file_addr", fa, file_addr);
    @(negedge clk);
    // flushed slot: a valid instruction that must be ignored
    if (n.busy) begin
      instr = '{1'b1, sbie_pkg::SBIE_OP_INC_FILE, 7'($urandom), 1'b1, 11'h000};
      file_rd = 8'($urandom);
      @(negedge clk);
    end
  endtask
  // watch outputs, pair each result with the oldest note
  initial begin
    sbie_note_t n;
    logic want_done;
    want_done = 1'b0;
    forever begin
      @(posedge clk);
      #1;
      if (want_done) check("done_q", 1, done_q);
      if (!rst && (busy_q || (done_q && !want_done))) begin
        if (notes.size() > 0) n = notes.pop_front();
        else n = 'x;
        check("file_wr.we", n.we, file_wr.we);
        if (n.we) check("file_wr", {n.addr, n.data}, {file_wr.addr, file_wr.data});
        check("work_q", n.work, work_q);
        check("zero_q", n.zero, zero_q);
        check("pc_q", n.pc, pc_q);
        check("busy_q", n.busy, busy_q);
        check("pc_load_q", n.pcl, pc_load_q);
      end
      want_done = busy_q;
    end
  end
  // watchdog
  initial begin
    #100us;
    err_count++;
    summarize();
  end
  // main sequence
  initial begin
    sbie_pkg::sbie_op_t op;
    rst = 1'b1;
    instr = '0;
    file_rd = 8'h00;
    pc_latch_high = 7'h55;
    {m_work, m_zero, m_pc} = 24'h00_0000;
    err_count = 0;
    samples_checked = 0;
    void'($urandom(30904));
    repeat (12) @(negedge clk);
    check("reset work pc", 0, {work_q, pc_q});
    check("reset pulses", 0, {zero_q, pc_load_q, busy_q, done_q, file_wr.we});
    rst = 1'b0;
    issue(sbie_pkg::SBIE_OP_DEC_SKIP, 7'h10, 1'b1, 11'h000, 8'h01);
    issue(sbie_pkg::SBIE_OP_DEC_SKIP, 7'h11, 1'b0, 11'h000, 8'h00);
    issue(sbie_pkg::SBIE_OP_INC_SKIP, 7'h12, 1'b0, 11'h000, 8'hff);
    issue(sbie_pkg::SBIE_OP_INC_SKIP, 7'h7f, 1'b1, 11'h000, 8'h7f);
    issue(sbie_pkg::SBIE_OP_OR_LIT, 7'h00, 1'b0, 11'h000, 8'h00);
    issue(sbie_pkg::SBIE_OP_INC_FILE, 7'h00, 1'b0, 11'h000, 8'hff);
    issue(sbie_pkg::SBIE_OP_JUMP, 7'h00, 1'b0, 11'h7ff, 8'h00);
    issue(sbie_pkg::sbie_op_t'(3'd7), 7'h05, 1'b1, 11'h000, 8'h10);
    issue(sbie_pkg::SBIE_OP_OR_LIT, 7'h33, 1'b1, 11'h0a5, 8'h00);
    issue(sbie_pkg::SBIE_OP_INC_FILE, 7'h01, 1'b1, 11'h000, 8'h41);
    // random back-to-back mix
    for (int i = 0; i < 80; i++) begin
      op = sbie_pkg::sbie_op_t'(3'($urandom_range(5, 1)));
      pc_latch_high = 7'($urandom);
      issue(op, 7'($urandom), 1'($urandom), 11'(op == sbie_pkg::SBIE_OP_OR_LIT ? $urandom_range(255, 0) : $urandom),
            8'($urandom_range(3, 0) == 0 ? 8'hff : $urandom));
    end
    instr.valid = 1'b0;
    repeat (4) @(negedge clk);
    check("notes left", 0, notes.size());
    summarize();
  end
endmodule // sbie_exec_tb
`default_nettype wire
